// File: rtl/word_load_pkg.sv
// Constants for the word load execution block
package word_load_pkg;
    localparam logic [7:0]  OPC_INDEXED     = 8'h07;
    localparam logic [7:0]  OPC_DIRECT      = 8'h87;
    localparam int          DISP_MSB        = 6;
    localparam int          MODE_BIT        = 7;
    localparam logic [15:0] HIGH_AREA_BASE  = 16'hfe00;
    localparam logic [15:0] PAIR_ADDR       = 16'hfe00;
    localparam logic [7:0]  PAIR_FILL       = 8'hff;
    localparam logic [15:0] LEN_INDEXED     = 16'h0002;
    localparam logic [15:0] LEN_DIRECT      = 16'h0003;
    localparam int          PSW_NINTH_POS   = 1;
    localparam logic [1:0]  CYC_NORMAL      = 2'h2;
    localparam logic [1:0]  CYC_HIGH        = 2'h3;
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC} state_type;
endpackage

// File: rtl/word_load_exec.sv
// Execution unit for the two word-load instructions into the A/B pair
// Notes on behaviour
// - Indexed form reads the word at pointer plus displacement; low byte to A, high byte to B.
// - The displacement is a 7-bit two's-complement value from -64 to +63.
// - The word's ninth bit, when present, is copied to status word bit 1 by either form.
// - Loading from the pair's own location puts all ones in B and leaves A undefined.
// - Opcode 10000111 is the direct form, followed by low then high address byte.
// - The direct form takes two cycles, three for addresses fe00 to ffff.
// - The direct form advances the program counter by three.
// - The direct form puts the low byte of the word in A and the high byte in B.
// - Opcode 00000111 with second byte bit 7 set is the indexed form, displacement in bits 6..0.
// - The indexed form advances the program counter by two and takes two or three cycles.
`timescale 1ns/1ns
module word_load_exec
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_ce,
    input  wire logic        i_start,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [7:0]  i_byte1,
    input  wire logic [7:0]  i_byte2,
    input  wire logic [15:0] i_first_indirect_pointer,
    input  wire logic [15:0] i_pc,
    input  wire logic [7:0]  i_program_status_word,
    input  wire logic [15:0] i_mem_rdata,
    input  wire logic        i_word_ninth_bit,
    input  wire logic        i_has_ninth_bit,
    output logic             o_busy,
    output logic             o_illegal,
    output logic [15:0]      o_mem_addr,
    output logic             o_done,
    output logic [7:0]       o_acc,
    output logic [7:0]       o_b,
    output logic [15:0]      o_pc,
    output logic [7:0]       o_program_status_word
);
    word_load_pkg::state_type state_r;
    logic [1:0]  cnt_r;
    logic [1:0]  cyc_r;
    logic [15:0] addr_r;
    logic [15:0] len_r;
    word_load_pkg::state_type state_nxt;

    function automatic logic [15:0] sext7(input logic [6:0] d);
        sext7 = {{9{d[word_load_pkg::DISP_MSB]}}, d};
    endfunction

    wire logic        is_direct  = (i_opcode == word_load_pkg::OPC_DIRECT);
    wire logic        is_indexed = (i_opcode == word_load_pkg::OPC_INDEXED)
                                   && i_byte1[word_load_pkg::MODE_BIT];
    // 16-bit sum wraps naturally
    wire logic [15:0] idx_addr   = i_first_indirect_pointer + sext7(i_byte1[6:0]);
    wire logic [15:0] dir_addr   = {i_byte2, i_byte1};
    wire logic [15:0] new_addr   = is_direct ? dir_addr : idx_addr;
    wire logic        high_area  = (new_addr >= word_load_pkg::HIGH_AREA_BASE);
    wire logic [1:0]  new_cyc    = high_area ? word_load_pkg::CYC_HIGH : word_load_pkg::CYC_NORMAL;
    wire logic        accept     = i_ce && i_start && (state_r == word_load_pkg::ST_IDLE);
    wire logic        finish     = i_ce && (state_r == word_load_pkg::ST_EXEC) && (cnt_r + 2'h1 == cyc_r);
    wire logic        self_pair  = (addr_r == word_load_pkg::PAIR_ADDR);
    wire logic        legal      = is_direct || is_indexed;
    wire logic [15:0] new_len    = is_direct ? word_load_pkg::LEN_DIRECT : word_load_pkg::LEN_INDEXED;

    assign o_busy     = (state_r == word_load_pkg::ST_EXEC);
    assign o_mem_addr = addr_r;

    // Two states suffice; the cycle count lives in cnt_r so the state stays small
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            word_load_pkg::ST_IDLE:
            begin
                if (accept && legal)
                    state_nxt = word_load_pkg::ST_EXEC;
            end
            word_load_pkg::ST_EXEC:
            begin
                if (finish)
                    state_nxt = word_load_pkg::ST_IDLE;
            end
            default:
                state_nxt = word_load_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            state_r <= word_load_pkg::ST_IDLE;
        else if (i_ce)
            state_r <= state_nxt;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            cnt_r <= 2'h0;
        else if (i_ce)
        begin
            if (accept)
                cnt_r <= 2'h0;
            else if (o_busy && !finish)
                cnt_r <= cnt_r + 2'h1;
        end
    end

    // Operands are captured once, so the caller may change its bytes while busy
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            cyc_r  <= word_load_pkg::CYC_NORMAL;
            addr_r <= 16'h0000;
            len_r  <= 16'h0000;
        end
        else if (accept && legal)
        begin
            cyc_r  <= new_cyc;
            addr_r <= new_addr;
            len_r  <= new_len;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_illegal <= 1'b0;
        else if (i_ce)
            o_illegal <= accept && !legal;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_done <= 1'b0;
        else if (i_ce)
            o_done <= finish;
    end

    // Pair location reads back unreliably; A just takes the bus low byte
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_acc <= 8'h00;
        else if (finish)
            o_acc <= i_mem_rdata[7:0];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_b <= 8'h00;
        else if (finish)
            o_b <= self_pair ? word_load_pkg::PAIR_FILL : i_mem_rdata[15:8];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_pc <= 16'h0000;
        else if (finish)
            o_pc <= i_pc + len_r;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_program_status_word <= 8'h00;
        else if (finish)
        begin
            o_program_status_word <= i_program_status_word;
            if (i_has_ninth_bit)
                o_program_status_word[word_load_pkg::PSW_NINTH_POS] <= i_word_ninth_bit;
        end
    end

    a_direct_len: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (accept && is_direct) |-> ##1 (len_r == 16'h0003)) else $error("direct length wrong");
    a_indexed_len: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (accept && is_indexed && !is_direct) |-> ##1 (len_r == 16'h0002)) else $error("indexed length wrong");
    a_index_addr: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (accept && is_indexed) |=> (addr_r == $past(idx_addr))) else $error("indexed address wrong");
    a_disp_sign: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (accept && is_indexed && i_byte1[6]) |=> (addr_r - $past(i_first_indirect_pointer)) >= 16'hffc0)
        else $error("displacement not negative");
    a_dir_addr: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (accept && is_direct) |=> (addr_r == {$past(i_byte2), $past(i_byte1)})) else $error("direct address wrong");
    a_cycle_count: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (accept && (is_direct || is_indexed) && !high_area) |=> (cyc_r == 2'h2)) else $error("normal cycle count");
    a_high_cycles: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (accept && (is_direct || is_indexed) && high_area) |=> (cyc_r == 2'h3)) else $error("high cycle count");
    a_pair_fill: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (finish && self_pair) |=> (o_b == 8'hff)) else $error("pair fill wrong");
    a_word_bytes: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (finish && !self_pair) |=> (o_acc == $past(i_mem_rdata[7:0]) && o_b == $past(i_mem_rdata[15:8])))
        else $error("byte placement wrong");
    a_ninth_copy: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (finish && i_has_ninth_bit) |=> (o_program_status_word[1] == $past(i_word_ninth_bit)))
        else $error("ninth bit not copied");
    a_flags_kept: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        finish |=> ({o_program_status_word[7:2], o_program_status_word[0]}
                    == {$past(i_program_status_word[7:2]), $past(i_program_status_word[0])}))
        else $error("other flags changed");
    a_ce_freeze: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !i_ce |=> (state_r == $past(state_r) && cnt_r == $past(cnt_r) && o_b == $past(o_b)))
        else $error("state moved while disabled");
    a_done_pulse: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_done && i_ce) |=> !o_done) else $error("done longer than one cycle");
    a_illegal_idle: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        o_illegal |-> !o_busy) else $error("refused encoding started");

    c_direct: cover property (@(posedge i_ref_clk) accept && is_direct);
    c_indexed: cover property (@(posedge i_ref_clk) accept && is_indexed);
    c_high: cover property (@(posedge i_ref_clk) finish && cyc_r == 2'h3);
    c_pair: cover property (@(posedge i_ref_clk) finish && self_pair);
    c_refused: cover property (@(posedge i_ref_clk) o_illegal);
endmodule

// File: bench/word_mem_model.sv
// Behavioural word memory that answers the load unit's read address
`timescale 1ns/1ns
module word_mem_model
(
    input  wire logic [15:0] i_addr,
    output logic [15:0]      o_rdata,
    output logic             o_ninth,
    output logic             o_has_ninth
);
    // Content follows the address, so a wrong address always gives wrong data
    assign o_rdata     = {i_addr[7:0] ^ 8'h3c, i_addr[15:8] ^ 8'h5a};
    assign o_ninth     = ^i_addr;
    assign o_has_ninth = i_addr[1];
endmodule

// File: bench/word_load_to_pair_execute_bench.sv
// Self-checking bench for the word load execution unit
`timescale 1ns/1ns
module word_load_to_pair_execute_bench;
    logic        i_ref_clk = 1'b0;
    logic        i_reset   = 1'b1;
    logic        i_start   = 1'b0;
    logic [7:0]  i_opcode  = 8'h00;
    logic [7:0]  i_byte1   = 8'h00;
    logic [7:0]  i_byte2   = 8'h00;
    logic [15:0] i_ptr     = 16'h0000;
    logic        ce        = 1'b1;
    logic [7:0]  psw_in    = 8'h5a;
    logic [15:0] rdata, o_mem_addr, o_pc;
    logic        ninth, has9, o_busy, o_illegal, o_done;
    logic [7:0]  o_acc, o_b, o_psw;
    int          failures  = 0;
    int          compares  = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    word_load_exec word_load_exec_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ce(ce), .i_start(i_start),
        .i_opcode(i_opcode), .i_byte1(i_byte1), .i_byte2(i_byte2), .i_first_indirect_pointer(i_ptr),
        .i_pc(16'h1f09), .i_program_status_word(psw_in), .i_mem_rdata(rdata), .i_word_ninth_bit(ninth),
        .i_has_ninth_bit(has9), .o_busy(o_busy), .o_illegal(o_illegal), .o_mem_addr(o_mem_addr),
        .o_done(o_done), .o_acc(o_acc), .o_b(o_b), .o_pc(o_pc), .o_program_status_word(o_psw));
    word_mem_model word_mem_model_i (.i_addr(o_mem_addr), .o_rdata(rdata), .o_ninth(ninth), .o_has_ninth(has9));
    task close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            failures++;
        end
    endtask
    // Issues one load and judges every result against the address it should have read, except A at the pair location fe00
    task go(input logic [7:0] op, b1, b2, input logic [15:0] ptr, ea, input int cyc, input logic [15:0] len);
        int n;
        n = 0;
        @(negedge i_ref_clk);
        {i_opcode, i_byte1, i_byte2, i_ptr, i_start} = {op, b1, b2, ptr, 1'b1};
        @(negedge i_ref_clk);
        i_start = 1'b0;
        while (o_done !== 1'b1 && n < 8)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        if (n == 8)
        begin
            failures++;
            close_out();
        end
        else
        begin
            check("address", o_mem_addr, ea);
            check("cycles", 16'(n), 16'(cyc));
            check("b", {8'h00, o_b}, {8'h00, (ea == 16'hfe00) ? 8'hff : ea[7:0] ^ 8'h3c});
            if (ea != 16'hfe00) check("acc", {8'h00, o_acc}, {8'h00, ea[15:8] ^ 8'h5a});
            check("pc", o_pc, 16'h1f09 + len);
            // Model gives a ninth bit where address bit 1 is set, equal to the address parity
            check("psw", {8'h00, o_psw}, {8'h00, ea[1] ? {psw_in[7:2], ^ea, psw_in[0]} : psw_in});
        end
    endtask
    // Freezes a direct load in mid-flight; the frozen cycles must not count
    task t_ce;
        int n;
        n = 0;
        @(negedge i_ref_clk);
        {i_opcode, i_byte1, i_byte2, i_start} = {8'h87, 8'h34, 8'h00, 1'b1};
        @(negedge i_ref_clk);
        {i_start, ce} = 2'b00;
        repeat (3) @(negedge i_ref_clk);
        check("busy held", {15'h0000, o_busy}, 16'h0001);
        check("done held", {15'h0000, o_done}, 16'h0000);
        ce = 1'b1;
        while (o_done !== 1'b1 && n < 8)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        if (n == 8)
        begin
            failures++;
            close_out();
        end
        else
        begin
            check("cycles after freeze", 16'(n), 16'h0002);
            check("b after freeze", {8'h00, o_b}, 16'h0008);
            $display("clock enable done");
        end
    endtask
    // Reset in mid-load clears every result, then a load must work at once
    task t_reset;
        @(negedge i_ref_clk);
        {i_opcode, i_byte1, i_byte2, i_start} = {8'h87, 8'h00, 8'hff, 1'b1};
        @(negedge i_ref_clk);
        {i_start, i_reset} = 2'b01;
        @(negedge i_ref_clk);
        i_reset = 1'b0;
        check("busy reset", {15'h0000, o_busy}, 16'h0000);
        check("done reset", {15'h0000, o_done}, 16'h0000);
        check("addr reset", o_mem_addr, 16'h0000);
        check("acc reset", {8'h00, o_acc}, 16'h0000);
        check("b reset", {8'h00, o_b}, 16'h0000);
        check("pc reset", o_pc, 16'h0000);
        check("psw reset", {8'h00, o_psw}, 16'h0000);
        go(8'h87, 8'h12, 8'h00, 16'h0000, 16'h0012, 2, 16'h0003);
        $display("mid-run reset done");
    endtask
    task t_direct;
        go(8'h87, 8'h12, 8'h00, 16'h0000, 16'h0012, 2, 16'h0003);
        go(8'h87, 8'h12, 8'hfe, 16'h0000, 16'hfe12, 3, 16'h0003);
        go(8'h87, 8'hff, 8'hfd, 16'h0000, 16'hfdff, 2, 16'h0003);
        $display("direct loads done");
    endtask
    task t_indexed;
        go(8'h07, 8'h84, 8'h00, 16'h0000, 16'h0004, 2, 16'h0002);
        go(8'h07, 8'hbf, 8'h00, 16'h0102, 16'h0141, 2, 16'h0002);
        go(8'h07, 8'hc0, 8'h00, 16'h0010, 16'hffd0, 3, 16'h0002);
        $display("indexed loads done");
    endtask
    task t_pair;
        go(8'h87, 8'h00, 8'hfe, 16'h0000, 16'hfe00, 3, 16'h0003);
        go(8'h07, 8'h80, 8'h00, 16'hfe00, 16'hfe00, 3, 16'h0002);
        $display("pair location loads done");
    endtask
    task t_illegal;
        @(negedge i_ref_clk);
        {i_opcode, i_byte1, i_start} = {8'h07, 8'h04, 1'b1};
        @(negedge i_ref_clk);
        i_start = 1'b0;
        check("illegal", {15'h0000, o_illegal}, 16'h0001);
        check("busy", {15'h0000, o_busy}, 16'h0000);
        $display("refused encoding done");
    endtask
    initial
    begin
        repeat (8) @(negedge i_ref_clk);
        i_reset = 1'b0;
        t_direct();
        t_indexed();
        t_pair();
        t_ce();
        t_reset();
        t_illegal();
        close_out();
    end
endmodule
